// ==== design/icr_top.v ====
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "icr_defines.vh"
// How it works
// R1: mirror register reads the primary status without clearing it
// R2: arm bit set: pin falling edge traps, trap clears arm bit
// R3: lock bit set: every falling edge traps, arm bit ignored
// R4: lock bit only cleared by reset, software writes cannot clear it
// R5: pin bit reads present pin level, writes to it are dropped
// R6: reset clears arm, lock and test-enable bits
// R7: software writes zero to reserved control bits
// R8: test-enable acts only while factory test mode input is high
// R9: test active: sources replaced by two test registers, reset zero
// R10: vector register follows highest enabled pending request
// R11: vector register read-only, six-bit code, bits 7 and 6 zero
// R12: vector is registered, stable whenever the core reads it
// R13: higher request number wins, request 31 highest
// R14: vector code is the binary request number selected
// R15: mask bits enable when one, both masks reset to all ones
// R16: request 0 unconnected unless test feature is active
// R17: raw status shows request levels regardless of masks
// R18: debug captures vector on vector read and on request to core
// R19: maskable request passes only when local and global enables set
// R20: reset sets local enable, clears global enable
// R21: entry pushes status word, clears global; return restores it
// R22: unmask/mask-off inputs set/clear local enable in one step
// R23: dispatch base 21 bits, top five and bit zero held zero
// R24: software keeps dispatch table at even address in program memory
// R25: stack pointer steps on entry and return, lsb and top bits zero
// R26: primary status set by trap, cleared on reset and on read
module icr_top (
    input  wire        core_clk_i,       // system clock
    input  wire        rst_n_i,          // synchronous reset, low
    input  wire        psel_i,           // apb select
    input  wire        penable_i,        // apb enable
    input  wire        pwrite_i,         // apb direction
    input  wire [11:0] paddr_i,          // apb byte address
    input  wire [31:0] pwdata_i,         // apb write data
    output wire [31:0] prdata_o,         // apb read data
    output wire        pready_o,         // apb ready
    output wire        pslverr_o,        // apb error, unmapped
    input  wire        nmi_pin_i,        // non-maskable pin level
    input  wire [31:0] irq_i,            // maskable request levels
    input  wire        factory_test_i,   // factory test mode
    input  wire        intr_entry_i,     // core takes an interrupt
    input  wire        exc_return_i,     // exception return executed
    input  wire [15:0] restore_psw_i,    // status word popped on return
    input  wire        unmask_i,         // unmask instruction
    input  wire        mask_off_i,       // mask-off instruction
    output wire        nmi_trap_o,       // trap pulse to core
    output wire        irq_req_o,        // maskable request to core
    output wire [5:0]  vector_o,         // vector code to core
    output wire [15:0] psw_o,            // processor status word
    output wire [15:0] pushed_psw_o,     // status word stacked on entry
    output wire [20:0] isp_o,            // interrupt stack pointer
    output wire [20:0] base_o            // dispatch table base
);

// ****************************************************************
// state
// ****************************************************************
reg        pready_r;
reg        pslverr_r;
reg [31:0] prdata_r;
reg        nmi_prev_r;
reg        arm_r;
reg        lock_r;
reg        tst_r;
reg        nm_ext_r;
reg        trap_r;
wire [15:0] mask_lo_r;
wire [15:0] mask_hi_r;
wire [15:0] test_lo_r;
wire [15:0] test_hi_r;
reg [31:0] raw_r;
reg [5:0]  vector_r;
reg        pend_r;
reg        irq_req_r;
reg [5:0]  dbg_read_r;
reg [5:0]  dbg_send_r;
reg [15:0] psw_r;
reg [15:0] pushed_r;
reg [20:0] isp_r;
reg [20:0] base_r;

// ****************************************************************
// bus decode
// ****************************************************************
wire acc_go   = psel_i & penable_i & ~pready_r;
wire acc_done = psel_i & penable_i & pready_r;
wire wr_done  = acc_done & pwrite_i;
wire rd_done  = acc_done & ~pwrite_i;

reg [31:0] rdata_nxt;
reg        hit_nxt;
always @* begin
    rdata_nxt = `ICR_ZERO32;
    hit_nxt   = 1'b1;
    case (paddr_i)
        `ICR_A_NM_PRIMARY: rdata_nxt[`ICR_NM_EXT] = nm_ext_r; // [R26]
        `ICR_A_NM_MIRROR:  rdata_nxt[`ICR_NM_EXT] = nm_ext_r; // [R1]
        `ICR_A_NM_PINCTL: begin
            rdata_nxt[`ICR_PC_ARM]  = arm_r;
            rdata_nxt[`ICR_PC_PIN]  = nmi_pin_i;              // [R5]
            rdata_nxt[`ICR_PC_LOCK] = lock_r;
            rdata_nxt[`ICR_PC_TST]  = tst_r;
        end
        `ICR_A_VECTOR:  rdata_nxt[5:0]  = vector_r;           // [R11]
        `ICR_A_MASK_LO: rdata_nxt[15:0] = mask_lo_r;
        `ICR_A_MASK_HI: rdata_nxt[15:0] = mask_hi_r;
        `ICR_A_RAW_LO:  rdata_nxt[15:0] = raw_r[15:0];        // [R17]
        `ICR_A_RAW_HI:  rdata_nxt[15:0] = raw_r[31:16];       // [R17]
        `ICR_A_TEST_LO: rdata_nxt = `ICR_ZERO32;
        `ICR_A_TEST_HI: rdata_nxt = `ICR_ZERO32;
        `ICR_A_DEBUG:   rdata_nxt[11:0] = {dbg_send_r, dbg_read_r};
        `ICR_A_PSW:     rdata_nxt[15:0] = psw_r;
        `ICR_A_BASE:    rdata_nxt[20:0] = base_r;
        `ICR_A_ISP:     rdata_nxt[20:0] = isp_r;
        default:        hit_nxt = 1'b0;
    endcase
end

// answer one cycle into the access phase
always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
        pready_r  <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r  <= `ICR_ZERO32;
    end else begin
        pready_r  <= acc_go;
        pslverr_r <= acc_go & ~hit_nxt;
        if (acc_go & ~pwrite_i)
            prdata_r <= rdata_nxt;
    end
end

// ****************************************************************
// non-maskable trap
// ****************************************************************
wire pin_fall = nmi_prev_r & ~nmi_pin_i;
wire trap_now = pin_fall & (lock_r | arm_r);                    // [R2] [R3]
wire pc_wr    = wr_done & (paddr_i == `ICR_A_NM_PINCTL);

always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
        nmi_prev_r <= 1'b1;
        arm_r      <= 1'b0;                                      // [R6]
        lock_r     <= 1'b0;                                      // [R6]
        tst_r      <= 1'b0;                                      // [R6]
        nm_ext_r   <= 1'b0;                                      // [R26]
        trap_r     <= 1'b0;
    end else begin
        nmi_prev_r <= nmi_pin_i;
        trap_r     <= trap_now;
        // a software set of the arm bit wins over the trap clear
        if (pc_wr)
            arm_r <= pwdata_i[`ICR_PC_ARM];
        else if (trap_now)
            arm_r <= 1'b0;                                       // [R2]
        if (pc_wr) begin
            lock_r <= lock_r | pwdata_i[`ICR_PC_LOCK];          // [R4]
            tst_r  <= pwdata_i[`ICR_PC_TST];
        end
        // set wins over clear-on-read
        if (trap_now)
            nm_ext_r <= 1'b1;                                    // [R26]
        else if (rd_done & (paddr_i == `ICR_A_NM_PRIMARY))
            nm_ext_r <= 1'b0;                                    // [R26]
    end
end

// ****************************************************************
// maskable sources, priority and vector
// ****************************************************************
wire        test_on = tst_r & factory_test_i;                   // [R8]
wire [31:0] src_nxt = test_on ? {test_hi_r, test_lo_r}           // [R9]
                              : {irq_i[31:1], 1'b0};             // [R16]
wire [31:0] pend    = raw_r & {mask_hi_r, mask_lo_r};            // [R15]

reg [5:0] vec_nxt;
reg       any_nxt;
integer   k;
always @* begin
    vec_nxt = `ICR_VEC_NONE;
    any_nxt = 1'b0;
    for (k = 0; k < 32; k = k + 1) begin
        if (pend[k]) begin
            vec_nxt = k[5:0];                                    // [R13] [R14]
            any_nxt = 1'b1;
        end
    end
end

wire enables_on = psw_r[`ICR_PSW_E] & psw_r[`ICR_PSW_I];
// request drops at once when the core takes it, so it is not taken twice
wire send_ok    = pend_r & enables_on & ~intr_entry_i;          // [R19]

always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
        raw_r      <= `ICR_ZERO32;
        vector_r   <= `ICR_VEC_NONE;
        pend_r     <= 1'b0;
        irq_req_r  <= 1'b0;
    end else begin
        raw_r     <= src_nxt;                                    // [R17]
        vector_r  <= vec_nxt;                                    // [R10] [R12]
        pend_r    <= any_nxt;
        irq_req_r <= send_ok;                                    // [R19]
    end
end

// ****************************************************************
// mask and test words
// ****************************************************************
icr_word_reg #(
    .RST_VAL (`ICR_MASK_RST),
    .ADDR    (`ICR_A_MASK_LO)
) mask_lo_u (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_i       (wr_done),
    .paddr_i    (paddr_i),
    .wdata_i    (pwdata_i[15:0]),
    .q_o        (mask_lo_r)                                      // [R15]
);

icr_word_reg #(
    .RST_VAL (`ICR_MASK_RST),
    .ADDR    (`ICR_A_MASK_HI)
) mask_hi_u (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_i       (wr_done),
    .paddr_i    (paddr_i),
    .wdata_i    (pwdata_i[15:0]),
    .q_o        (mask_hi_r)                                      // [R15]
);

icr_word_reg #(
    .RST_VAL (`ICR_TEST_RST),
    .ADDR    (`ICR_A_TEST_LO)
) test_lo_u (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_i       (wr_done),
    .paddr_i    (paddr_i),
    .wdata_i    (pwdata_i[15:0]),
    .q_o        (test_lo_r)                                      // [R9]
);

icr_word_reg #(
    .RST_VAL (`ICR_TEST_RST),
    .ADDR    (`ICR_A_TEST_HI)
) test_hi_u (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_i       (wr_done),
    .paddr_i    (paddr_i),
    .wdata_i    (pwdata_i[15:0]),
    .q_o        (test_hi_r)                                      // [R9]
);

// ****************************************************************
// vector debug capture
// ****************************************************************
// the send slot is the cycle in which the request line rises
always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
        dbg_read_r <= `ICR_VEC_NONE;                             // [R18]
        dbg_send_r <= `ICR_VEC_NONE;                             // [R18]
    end else begin
        if (rd_done & (paddr_i == `ICR_A_VECTOR))
            dbg_read_r <= vector_r;                              // [R18]
        if (send_ok & ~irq_req_r)
            dbg_send_r <= vector_r;                              // [R18]
    end
end

// ****************************************************************
// core status word, dispatch base, stack pointer
// ****************************************************************
always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
        psw_r    <= `ICR_PSW_RST;                                // [R20]
        pushed_r <= `ICR_PSW_RST;
        isp_r    <= `ICR_ADDR_RST;
        base_r   <= `ICR_ADDR_RST;
    end else begin
        if (intr_entry_i) begin
            pushed_r           <= psw_r;                         // [R21]
            psw_r[`ICR_PSW_I]  <= 1'b0;                          // [R21]
            isp_r <= (isp_r - `ICR_ISP_STEP) & `ICR_ADDR_MASK;   // [R25]
        end else if (exc_return_i) begin
            psw_r <= restore_psw_i;                              // [R21]
            isp_r <= (isp_r + `ICR_ISP_STEP) & `ICR_ADDR_MASK;   // [R25]
        end else if (unmask_i) begin
            psw_r[`ICR_PSW_E] <= 1'b1;                           // [R22]
        end else if (mask_off_i) begin
            psw_r[`ICR_PSW_E] <= 1'b0;                           // [R22]
        end else if (wr_done & (paddr_i == `ICR_A_PSW)) begin
            psw_r <= pwdata_i[15:0];
        end else if (wr_done & (paddr_i == `ICR_A_ISP)) begin
            isp_r <= pwdata_i[20:0] & `ICR_ADDR_MASK;            // [R25]
        end
        if (wr_done & (paddr_i == `ICR_A_BASE))
            base_r <= pwdata_i[20:0] & `ICR_ADDR_MASK;           // [R23]
    end
end

// ****************************************************************
// outputs
// ****************************************************************
assign prdata_o     = prdata_r;
assign pready_o     = pready_r;
assign pslverr_o    = pslverr_r;
assign nmi_trap_o   = trap_r;
assign irq_req_o    = irq_req_r;
assign vector_o     = vector_r;
assign psw_o        = psw_r;
assign pushed_psw_o = pushed_r;
assign isp_o        = isp_r;
assign base_o       = base_r;

endmodule // icr_top

// ****************************************************************
// one software-written register word
// ****************************************************************
module icr_word_reg #(
    parameter [15:0] RST_VAL = `ICR_TEST_RST,  // value after reset
    parameter [11:0] ADDR    = `ICR_A_TEST_LO  // byte address
) (
    input  wire        core_clk_i,   // system clock
    input  wire        rst_n_i,      // synchronous reset, low
    input  wire        wr_i,         // completed apb write
    input  wire [11:0] paddr_i,      // apb byte address
    input  wire [15:0] wdata_i,      // low half of write data
    output reg  [15:0] q_o           // register contents
);

always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
        q_o <= RST_VAL;
    end else if (wr_i & (paddr_i == ADDR)) begin
        q_o <= wdata_i;
    end
end

endmodule // icr_word_reg

// ==== include/icr_defines.vh ====
`ifndef ICR_DEFINES_VH
`define ICR_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ICR_A_NM_PRIMARY   12'h000
`define ICR_A_NM_MIRROR    12'h004
`define ICR_A_NM_PINCTL    12'h008
`define ICR_A_VECTOR       12'h00c
`define ICR_A_MASK_LO      12'h010
`define ICR_A_MASK_HI      12'h014
`define ICR_A_RAW_LO       12'h018
`define ICR_A_RAW_HI       12'h01c
`define ICR_A_TEST_LO      12'h020
`define ICR_A_TEST_HI      12'h024
`define ICR_A_DEBUG        12'h028
`define ICR_A_PSW          12'h02c
`define ICR_A_BASE         12'h030
`define ICR_A_ISP          12'h034

// ****************************************************************
// field positions
// ****************************************************************
`define ICR_PC_ARM         0
`define ICR_PC_PIN         1
`define ICR_PC_LOCK        2
`define ICR_PC_TST         3
`define ICR_PSW_E          9
`define ICR_PSW_I          11
`define ICR_NM_EXT         0

// ****************************************************************
// reset values and masks
// ****************************************************************
`define ICR_MASK_RST       16'hffff
`define ICR_TEST_RST       16'h0000
`define ICR_DBG_RST        16'h0000
`define ICR_PSW_RST        16'h0200
`define ICR_ADDR_MASK      21'h00fffe
`define ICR_ADDR_RST       21'h000000
`define ICR_ISP_STEP       21'h000002
`define ICR_VEC_NONE       6'h00
`define ICR_ZERO32         32'h00000000

`endif

// ==== tb/icr_top_properties.sv ====
`timescale 1ns/1ps
module icr_top_properties (
    input wire logic        core_clk_i,     // clock
    input wire logic        rst_n_i,        // reset, low
    input wire logic        psel_i,         // apb select
    input wire logic        penable_i,      // apb enable
    input wire logic        pready_o,       // apb ready
    input wire logic        pslverr_o,      // apb error
    input wire logic        nmi_pin_i,      // nmi pin
    input wire logic        nmi_trap_o,     // trap pulse
    input wire logic        irq_req_o,      // request to core
    input wire logic        intr_entry_i,   // entry
    input wire logic        exc_return_i,   // return
    input wire logic [15:0] restore_psw_i,  // popped psw
    input wire logic        unmask_i,       // unmask
    input wire logic        mask_off_i,     // mask off
    input wire logic [15:0] psw_o,          // status word
    input wire logic [15:0] pushed_psw_o,   // stacked psw
    input wire logic [20:0] isp_o,          // stack pointer
    input wire logic [20:0] base_o          // table base
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no ready after wait state");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    trap_cause_a: assert property (nmi_trap_o |-> !$past(nmi_pin_i) && $past(nmi_pin_i, 2))
        else $error("trap without falling edge");
    trap_pulse_a: assert property (nmi_trap_o |=> !nmi_trap_o)
        else $error("trap longer than one cycle");
    req_gate_a: assert property (!(psw_o[9] && psw_o[11]) && !$past(psw_o[9] && psw_o[11]) |-> !irq_req_o)
        else $error("request while disabled");
    entry_push_a: assert property (intr_entry_i |=> !psw_o[11] && pushed_psw_o == $past(psw_o))
        else $error("entry did not push psw");
    entry_isp_a: assert property (intr_entry_i |=> isp_o == (($past(isp_o) - 21'h2) & 21'h00fffe))
        else $error("isp not stepped");
    return_psw_a: assert property (exc_return_i && !intr_entry_i |=> psw_o == $past(restore_psw_i))
        else $error("psw not restored");
    unmask_set_a: assert property (unmask_i && !intr_entry_i && !exc_return_i |=> psw_o[9])
        else $error("unmask failed");
    maskoff_clr_a: assert property (mask_off_i && !unmask_i && !intr_entry_i && !exc_return_i |=> !psw_o[9])
        else $error("mask off failed");
    addr_bits_a: assert property (isp_o[0] == 1'b0 && isp_o[20:16] == 5'h00 && base_o[0] == 1'b0 && base_o[20:16] == 5'h00)
        else $error("fixed address bits set");
endmodule // icr_top_properties
bind icr_top icr_top_properties chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .nmi_pin_i(nmi_pin_i), .nmi_trap_o(nmi_trap_o), .irq_req_o(irq_req_o),
    .intr_entry_i(intr_entry_i), .exc_return_i(exc_return_i),
    .restore_psw_i(restore_psw_i), .unmask_i(unmask_i), .mask_off_i(mask_off_i),
    .psw_o(psw_o), .pushed_psw_o(pushed_psw_o), .isp_o(isp_o), .base_o(base_o));

// ==== tb/icr_core_model.sv ====
`timescale 1ns/1ps
module icr_core_model (
    input  wire logic        core_clk_i,     // clock
    input  wire logic        rst_n_i,        // reset, low
    input  wire logic        irq_req_i,      // request from unit
    input  wire logic        ret_go_i,       // bench asks for return
    input  wire logic [15:0] pushed_psw_i,   // stacked psw
    output logic             intr_entry_o,   // entry pulse
    output logic             exc_return_o,   // return pulse
    output logic [15:0]      restore_psw_o   // psw popped
);
    // takes a request once, returns on command with the stacked word
    always @(posedge core_clk_i) begin
        intr_entry_o <= 1'b0;
        exc_return_o <= 1'b0;
        if (rst_n_i && irq_req_i && !intr_entry_o) intr_entry_o <= 1'b1;
        else if (rst_n_i && ret_go_i) exc_return_o <= 1'b1;
    end
    assign restore_psw_o = pushed_psw_i;
endmodule // icr_core_model

// ==== tb/interrupt_control_registers_bench.sv ====
`timescale 1ns/1ps
`include "icr_defines.vh"
module interrupt_control_registers_bench;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, nmi = 1, ftest = 0;
    logic ret_go = 0, unm = 0, moff = 0, rerr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, irq = 0, rdat;
    wire [31:0] prdata;
    wire pready, perr, trap, ireq, ient, iret;
    wire [5:0] vec;
    wire [15:0] psw, ppsw, rpsw;
    wire [20:0] interrupt_stack_pointer, base;
    int num_errors = 0, tests_run = 0, traps = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (trap === 1'b1) traps <= traps + 1;
    icr_top uut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .nmi_pin_i(nmi), .irq_i(irq),
        .factory_test_i(ftest), .intr_entry_i(ient), .exc_return_i(iret),
        .restore_psw_i(rpsw), .unmask_i(unm), .mask_off_i(moff), .nmi_trap_o(trap),
        .irq_req_o(ireq), .vector_o(vec), .psw_o(psw), .pushed_psw_o(ppsw),
        .isp_o(interrupt_stack_pointer), .base_o(base));
    icr_core_model core (.core_clk_i(clk), .rst_n_i(rst_n), .irq_req_i(ireq),
        .ret_go_i(ret_go), .pushed_psw_i(ppsw), .intr_entry_o(ient),
        .exc_return_o(iret), .restore_psw_o(rpsw));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = perr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic fall(input int n);
        repeat (n) begin
            @(posedge clk) nmi <= 1'b0;
            repeat (3) @(posedge clk);
            nmi <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(`ICR_A_MASK_LO, 32'hffff);
        rd(`ICR_A_MASK_HI, 32'hffff);
        rd(`ICR_A_DEBUG, 32'h0);
        rd(`ICR_A_NM_PINCTL, 32'h2);
        rd(`ICR_A_PSW, 32'h0200);
        rd(`ICR_A_TEST_LO, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test done: reset and map");
        apb(1'b1, `ICR_A_NM_PINCTL, 32'h1);
        rd(`ICR_A_NM_PINCTL, 32'h3);
        fall(1);
        chk(32'(traps), 32'h1);
        rd(`ICR_A_NM_PINCTL, 32'h2);
        rd(`ICR_A_NM_MIRROR, 32'h1);
        rd(`ICR_A_NM_MIRROR, 32'h1);
        rd(`ICR_A_NM_PRIMARY, 32'h1);
        rd(`ICR_A_NM_PRIMARY, 32'h0);
        fall(1);
        chk(32'(traps), 32'h1);
        apb(1'b1, `ICR_A_NM_PINCTL, 32'h4);
        fall(2);
        @(posedge clk) nmi <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(traps), 32'h4);
        rd(`ICR_A_NM_PINCTL, 32'h4);
        apb(1'b1, `ICR_A_NM_PINCTL, 32'h2);
        rd(`ICR_A_NM_PINCTL, 32'h4);
        nmi <= 1'b1;
        $display("test done: nmi");
        irq <= 32'h43;
        repeat (4) @(posedge clk);
        rd(`ICR_A_RAW_LO, 32'h42);
        rd(`ICR_A_VECTOR, 32'h6);
        apb(1'b1, `ICR_A_MASK_LO, 32'hffbf);
        rd(`ICR_A_VECTOR, 32'h1);
        rd(`ICR_A_RAW_LO, 32'h42);
        rd(`ICR_A_DEBUG, 32'h1);
        apb(1'b1, `ICR_A_MASK_LO, 32'hffff);
        apb(1'b1, `ICR_A_NM_PINCTL, 32'h8);
        rd(`ICR_A_RAW_LO, 32'h42);
        ftest <= 1'b1;
        rd(`ICR_A_RAW_LO, 32'h0);
        apb(1'b1, `ICR_A_TEST_HI, 32'h4);
        apb(1'b1, `ICR_A_TEST_LO, 32'h1);
        rd(`ICR_A_RAW_HI, 32'h4);
        rd(`ICR_A_RAW_LO, 32'h1);
        rd(`ICR_A_VECTOR, 32'h12);
        ftest <= 1'b0;
        apb(1'b1, `ICR_A_NM_PINCTL, 32'h0);
        $display("test done: maskable and test");
        irq <= 32'h8000_0000;
        apb(1'b1, `ICR_A_ISP, 32'he7fe);
        apb(1'b1, `ICR_A_BASE, 32'h1fbfc1);
        rd(`ICR_A_BASE, 32'hbfc0);
        apb(1'b1, `ICR_A_BASE, 32'h0004);
        rd(`ICR_A_BASE, 32'h0004);
        rd(`ICR_A_VECTOR, 32'h1f);
        chk({26'h0, vec}, 32'h1f);
        apb(1'b1, `ICR_A_PSW, 32'h0a00);
        repeat (10) @(posedge clk);
        chk({16'h0, ppsw}, 32'h0a00);
        rd(`ICR_A_PSW, 32'h0200);
        rd(`ICR_A_ISP, 32'he7fc);
        rd(`ICR_A_DEBUG, 32'h7df);
        irq <= 32'h0;
        @(posedge clk) ret_go <= 1'b1;
        @(posedge clk) ret_go <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`ICR_A_PSW, 32'h0a00);
        rd(`ICR_A_ISP, 32'he7fe);
        @(posedge clk) moff <= 1'b1;
        @(posedge clk) moff <= 1'b0;
        rd(`ICR_A_PSW, 32'h0800);
        @(posedge clk) unm <= 1'b1;
        @(posedge clk) unm <= 1'b0;
        rd(`ICR_A_PSW, 32'h0a00);
        $display("test done: core");
        wrap_up;
    end
endmodule // interrupt_control_registers_bench
